// file: logic/option_byte_config_decoder.sv
// Purpose: Programming access and decoding of the two configuration bytes
// Assumes: progMode is a pin level, synchronised here
// Notes: Decoded outputs are latched at reset release and frozen until next reset, except watchdogActive and haltReset, which follow their inputs
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder (
   input wire logic clk,
   input wire logic rst,
   input wire logic powerOnClear,
   input wire logic progMode,
   input wire logic progWrite,
   input wire logic progRead,
   input wire logic progAddr,
   input wire logic [7:0] progWrData,
   input wire logic watchdogSwEnable,
   input wire logic haltEntry,
   output logic [7:0] progRdData,
   output logic progRdValid,
   output logic [1:0] startupClockSelect,
   output logic externalSource,
   output logic externalClockInput,
   output logic [2:0] oscillatorRangeField,
   output logic lowPowerRange,
   output logic supplyDropDetectorOn,
   output logic watchdogForced,
   output logic watchdogActive,
   output logic wakeupVeryLowPower,
   output logic haltReset,
   output logic configLoaded
);
   // ************************************
   // State
   // ************************************
   // Decoded settings are flops so every output comes straight from a register
   typedef struct packed {
      logic progMeta;
      logic progSync;
      logic loaded;
      logic [7:0] rdData;
      logic rdValid;
      logic [7:0] b0;
      logic [7:0] b1;
      logic haltRst;
      logic [1:0] clkSel;
      logic extSrc;
      logic extClkIn;
      logic [2:0] oscillator_range_field;
      logic lowPwr;
      logic supplyOn;
      logic wdgForced;
      logic wdgAct;
      logic wakeSlow;
   } state_t;
   state_t s_q;
   state_t s_d;

   logic [7:0] storeB0;
   logic [7:0] storeB1;
   logic storeWr;

   // ************************************
   // Clock source decode
   // ************************************
   // start-up clock code
   function automatic option_cfg_pkg::clk_src_t src_of(input logic [7:0] b1);
      logic [1:0] sel;
      sel = b1[option_cfg_pkg::CLK_SEL_HI:option_cfg_pkg::CLK_SEL_LO];
      return option_cfg_pkg::clk_src_t'(sel);
   endfunction : src_of

   function automatic logic is_external(input logic [7:0] b1);
      return src_of(b1) inside {option_cfg_pkg::SRC_RESONATOR, option_cfg_pkg::SRC_EXTERNAL};
   endfunction : is_external

   // ************************************
   // Programming port and store
   // ************************************
   // writes gated by mode
   assign storeWr = s_q.progSync && progWrite;

   // Store keeps its content across rst; only powerOnClear erases it
   option_byte_store store (
      .clk(clk),
      .powerOnClear(powerOnClear),
      .wrEn(storeWr),
      .addr(progAddr),
      .wrData(progWrData),
      .byteZero(storeB0),
      .byteOne(storeB1)
   );

   // ************************************
   // Next state
   // ************************************
   always_comb begin
      s_d = s_q;
      s_d.progMeta = progMode;
      s_d.progSync = s_q.progMeta;
      s_d.rdValid = 1'b0;
      // capture once after reset
      // Later writes reach the store only; decode waits for the next reset
      if (!s_q.loaded) begin
         s_d.b0 = storeB0;
         s_d.b1 = storeB1;
         s_d.loaded = 1'b1;
      end
      if (s_q.progSync && progRead) begin
         s_d.rdData = (progAddr == option_cfg_pkg::ADDR_BYTE_ONE) ? storeB1 : storeB0;
         s_d.rdValid = 1'b1;
      end
      s_d.clkSel = src_of(s_d.b1);
      s_d.extSrc = is_external(s_d.b1);
      s_d.extClkIn = src_of(s_d.b1) == option_cfg_pkg::SRC_EXTERNAL;
      s_d.oscillator_range_field = s_d.b0[option_cfg_pkg::RANGE_HI:option_cfg_pkg::RANGE_LO];
      s_d.lowPwr = is_external(s_d.b1) && s_d.oscillator_range_field == option_cfg_pkg::RANGE_LOW_POWER;
      s_d.supplyOn = !s_d.b1[option_cfg_pkg::SUPPLY_BIT];
      s_d.wdgForced = !s_d.b1[option_cfg_pkg::WATCHDOG_TYPE_BIT];
      s_d.wdgAct = s_d.wdgForced || watchdogSwEnable;
      s_d.wakeSlow = !s_d.b0[option_cfg_pkg::WAKE_CLK_BIT];
      // halt reset when watchdog active
      // Uses the registered watchdog state so the output and the decision agree
      s_d.haltRst = s_q.loaded && s_q.wdgAct && haltEntry &&
         s_q.b1[option_cfg_pkg::HALT_RESET_BIT];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************
   // Outputs
   // ************************************
   assign startupClockSelect = s_q.clkSel;
   assign externalSource = s_q.extSrc;
   assign externalClockInput = s_q.extClkIn;
   assign oscillatorRangeField = s_q.oscillator_range_field;
   assign lowPowerRange = s_q.lowPwr;
   assign supplyDropDetectorOn = s_q.supplyOn;
   assign watchdogForced = s_q.wdgForced;
   assign watchdogActive = s_q.wdgAct;
   assign wakeupVeryLowPower = s_q.wakeSlow;
   assign haltReset = s_q.haltRst;
   assign progRdData = s_q.rdData;
   assign progRdValid = s_q.rdValid;
   assign configLoaded = s_q.loaded;

   // ************************************
   // Checks
   // ************************************
   // bind the programmer; not checked here
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence progReadSeq;
      s_q.progSync && progRead;
   endsequence

   sequence haltWithDogSeq;
      configLoaded && watchdogActive && haltEntry && s_q.b1[option_cfg_pkg::HALT_RESET_BIT];
   endsequence

   sequence loadedTwiceSeq;
      configLoaded ##1 configLoaded;
   endsequence

   noProgWrite_a: assert property (!s_q.progSync |-> !storeWr)
      else $error("store written outside programming mode");
   readGated_a: assert property (progRdValid |-> $past(s_q.progSync) && $past(progRead))
      else $error("read answered outside programming mode");
   readAnswer_a: assert property (progReadSeq |=> progRdValid)
      else $error("programming read not answered");
   rdHold_a: assert property (!(s_q.progSync && progRead) |=> $stable(progRdData))
      else $error("read data changed without a read");
   erasedRead_a: assert property ($fell(powerOnClear) |->
      (storeB0 & storeB1) == option_cfg_pkg::ERASED_BYTE)
      else $error("erased store not all ones");
   clockDecode_a: assert property (externalClockInput |->
      startupClockSelect == option_cfg_pkg::SRC_EXTERNAL)
      else $error("external clock decode wrong");
   extSource_a: assert property (configLoaded |->
      externalSource == s_q.b1[option_cfg_pkg::CLK_SEL_HI])
      else $error("source decode wrong");
   captureLoad_a: assert property ($rose(configLoaded) |->
      s_q.b1 == $past(storeB1) && s_q.b0 == $past(storeB0))
      else $error("bytes not captured at load");
   supplyOn_a: assert property (configLoaded |->
      supplyDropDetectorOn == !s_q.b1[option_cfg_pkg::SUPPLY_BIT])
      else $error("supervisor enable wrong");
   wdgForced_a: assert property (watchdogForced |-> watchdogActive)
      else $error("hardware watchdog not active");
   swDog_a: assert property (configLoaded |->
      watchdogActive == (watchdogForced || $past(watchdogSwEnable)))
      else $error("software watchdog enable not followed");
   haltRst_a: assert property (haltWithDogSeq |=> haltReset)
      else $error("halt reset missing");
   noHaltRst_a: assert property (haltReset |->
      $past(watchdogActive) && $past(haltEntry) &&
      $past(s_q.b1[option_cfg_pkg::HALT_RESET_BIT]))
      else $error("halt reset without option");
   wakeClk_a: assert property (configLoaded |->
      wakeupVeryLowPower != s_q.b0[option_cfg_pkg::WAKE_CLK_BIT])
      else $error("wake clock decode wrong");
   lowPower_a: assert property (lowPowerRange |->
      externalSource && oscillatorRangeField == option_cfg_pkg::RANGE_LOW_POWER)
      else $error("low power range decode wrong");
   lowPowerSet_a: assert property (configLoaded && externalSource &&
      oscillatorRangeField == option_cfg_pkg::RANGE_LOW_POWER |-> lowPowerRange)
      else $error("low power range not flagged");
   heldStable_a: assert property (loadedTwiceSeq |-> $stable(startupClockSelect) &&
      $stable(oscillatorRangeField) && $stable(supplyDropDetectorOn) &&
      $stable(wakeupVeryLowPower) && $stable(watchdogForced))
      else $error("settings changed after load");
endmodule : option_byte_config_decoder
`default_nettype wire

// file: logic/option_byte_store.sv
// Purpose: Non-volatile image of the two configuration bytes
// Assumes: Writes come only from the programming port
// Notes: Holds content across device reset; only a power-up clears to erased
`timescale 1ns/1ps
`default_nettype none
module option_byte_store (
   input wire logic clk,
   input wire logic powerOnClear,
   input wire logic wrEn,
   input wire logic addr,
   input wire logic [7:0] wrData,
   output logic [7:0] byteZero,
   output logic [7:0] byteOne
);
   typedef struct packed {
      logic [7:0] b0;
      logic [7:0] b1;
   } store_t;
   store_t s_q;
   store_t s_d;

   always_comb begin
      s_d = s_q;
      if (wrEn && addr == option_cfg_pkg::ADDR_BYTE_ZERO) begin
         s_d.b0 = wrData;
      end
      if (wrEn && addr == option_cfg_pkg::ADDR_BYTE_ONE) begin
         s_d.b1 = wrData;
      end
   end

   always_ff @(posedge clk or posedge powerOnClear) begin
      if (powerOnClear) begin
         s_q <= {option_cfg_pkg::ERASED_BYTE, option_cfg_pkg::ERASED_BYTE};
      end else begin
         s_q <= s_d;
      end
   end

   assign byteZero = s_q.b0;
   assign byteOne = s_q.b1;
endmodule : option_byte_store
`default_nettype wire

// file: logic/option_cfg_pkg.sv
// Purpose: Constants for the configuration byte store and decoder
// Assumes: Two 8-bit configuration bytes, erased value all ones
// Notes: Byte addresses and erased value shared by store and decoder; field positions used by the decoder only
`default_nettype none
package option_cfg_pkg;
   // ************************************
   // Byte selection and erased value
   // ************************************
   localparam logic ADDR_BYTE_ZERO = 1'h0;
   localparam logic ADDR_BYTE_ONE = 1'h1;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // ************************************
   // Byte one fields
   // ************************************
   localparam int CLK_SEL_HI = 7;
   localparam int CLK_SEL_LO = 6;
   localparam int RSVD_HI = 5;
   localparam int RSVD_LO = 3;
   localparam int SUPPLY_BIT = 2;
   localparam int WATCHDOG_TYPE_BIT = 1;
   localparam int HALT_RESET_BIT = 0;
   localparam logic [2:0] RSVD_ONES = 3'h7;
   // ************************************
   // Byte zero fields
   // ************************************
   localparam int WAKE_CLK_BIT = 7;
   localparam int RANGE_HI = 6;
   localparam int RANGE_LO = 4;
   localparam logic [2:0] RANGE_LOW_POWER = 3'h0;
   localparam logic [2:0] RANGE_WITH_SLOW_OSC = 3'h4;
   // ************************************
   // Clock source codes
   // ************************************
   typedef enum logic [1:0] {
      SRC_INTERNAL_RC = 2'h0,
      SRC_WAKEUP_RC = 2'h1,
      SRC_RESONATOR = 2'h2,
      SRC_EXTERNAL = 2'h3
   } clk_src_t;
endpackage : option_cfg_pkg
`default_nettype wire

// file: verification/option_byte_config_decoder_tb.sv
// Purpose: Self-checking bench for the option byte decoder
// Assumes: Inputs change on falling edges
// Notes: Decode is only refreshed by a reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errTotal++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module option_byte_config_decoder_tb;
   logic clk = 0, rst = 1, powerOnClear = 1, watchdogSwEnable = 0, haltEntry = 0;
   logic progMode, progWrite, progRead, progAddr, progRdValid, externalSource;
   logic externalClockInput, lowPowerRange, supplyDropDetectorOn, watchdogForced;
   logic watchdogActive, wakeupVeryLowPower, haltReset, configLoaded;
   logic [7:0] progWrData, progRdData, s, hz = 8'hff, ho = 8'hff;
   logic [1:0] startupClockSelect;
   logic [2:0] oscillatorRangeField;
   logic [7:0] mem [2] = '{8'hff, 8'hff};
   logic [15:0] lfsr = 16'h002f;
   int errTotal = 0, comparisons = 0;
   always #10 clk = ~clk;
   prog_tool_model i_tool (.clk, .progMode, .progWrite, .progRead, .progAddr, .progWrData);
   option_byte_config_decoder i_dut (.clk, .rst, .powerOnClear, .progMode, .progWrite,
      .progRead, .progAddr, .progWrData, .watchdogSwEnable, .haltEntry, .progRdData,
      .progRdValid, .startupClockSelect, .externalSource, .externalClockInput,
      .oscillatorRangeField, .lowPowerRange, .supplyDropDetectorOn, .watchdogForced,
      .watchdogActive, .wakeupVeryLowPower, .haltReset, .configLoaded);
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic decode(input logic [7:0] z, o);
      `CHK("clk select", o[7:6], startupClockSelect)
      `CHK("external", {o[7], &o[7:6]}, {externalSource, externalClockInput})
      `CHK("range", {z[6:4], o[7] && !z[6:4]}, {oscillatorRangeField, lowPowerRange})
      `CHK("supply", !o[2], supplyDropDetectorOn)
      `CHK("wdg forced", !o[1], watchdogForced)
      `CHK("wake clock", !z[7], wakeupVeryLowPower)
   endtask : decode
   task automatic rd_chk(input logic a, input logic v);
      i_tool.xfer(1'h0, a, 8'h00, s);
      `CHK("read valid", v, progRdValid)
      if (v) `CHK("read data", mem[a], progRdData)
   endtask : rd_chk
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (12) @(negedge clk);
      {rst, powerOnClear} = '0;
      @(negedge clk);
      `CHK("loaded", 1'h1, configLoaded)
      decode(8'hff, 8'hff);
      i_tool.enter(1'h1);
      rd_chk(1'h0, 1'h1);
      rd_chk(1'h1, 1'h1);
      $display("test erased done");
      for (int i = 0; i < 8; i++) begin
         // Strobes outside programming mode are ignored
         i_tool.enter(1'h0);
         i_tool.xfer(1'h1, i[0], 8'h5a, s);
         rd_chk(1'h0, 1'h0);
         i_tool.enter(1'h1);
         rd_chk(i[0], 1'h1);
         lfsr = nxt(lfsr);
         i_tool.xfer(1'h1, 1'h1, {i[1:0], lfsr[5:0]}, mem[1]);
         // Odd steps with i[2] set keep range 000 through legal(); step 7 also selects an external source, so the low-power decode is reached
         i_tool.xfer(1'h1, 1'h0, {i[2], i[0] ? 3'h0 : lfsr[14:12], lfsr[11:8]}, mem[0]);
         rd_chk(1'h0, 1'h1);
         rd_chk(1'h1, 1'h1);
         decode(hz, ho);
         @(negedge clk) rst = 1'h1;
         @(negedge clk) rst = 1'h0;
         @(negedge clk) {hz, ho} = {mem[0], mem[1]};
         decode(hz, ho);
         // Watchdog state is registered, so it settles one edge before halt
         watchdogSwEnable = lfsr[15];
         @(negedge clk) haltEntry = 1'h1;
         @(negedge clk) haltEntry = 1'h0;
         `CHK("wdg active", !ho[1] || lfsr[15], watchdogActive)
         `CHK("halt reset", (!ho[1] || lfsr[15]) && ho[0], haltReset)
         $display("test %0d done", i);
      end
      report_and_stop();
   end
   // Hang guard
   initial begin
      #2000000;
      errTotal++;
      report_and_stop();
   end
endmodule : option_byte_config_decoder_tb
`default_nettype wire

// file: verification/prog_tool_model.sv
// Purpose: Programming tool on the option byte port
// Assumes: Drives after falling edges
// Notes: Sends only legal byte images
`timescale 1ns/1ps
`default_nettype none
module prog_tool_model (
   input wire logic clk,
   output logic progMode,
   output logic progWrite,
   output logic progRead,
   output logic progAddr,
   output logic [7:0] progWrData
);
   initial {progMode, progWrite, progRead, progAddr, progWrData} = '0;
   // ****
   // Mode pin; sync needs two edges, task waits three
   // ****
   task automatic enter(input logic m);
      @(negedge clk) progMode = m;
      repeat (3) @(negedge clk);
   endtask : enter
   function automatic logic [7:0] legal(input logic a, input logic [7:0] v);
      return a ? (v | 8'h38) : (v[7] ? v : {4'h4, v[3:0]});
   endfunction : legal
   task automatic xfer(input logic w, a, input logic [7:0] v, output logic [7:0] s);
      s = legal(a, v);
      @(negedge clk) {progWrite, progRead, progAddr, progWrData} = {w, !w, a, s};
      @(negedge clk) {progWrite, progRead, progWrData} = {2'h0, ~s};
   endtask : xfer
endmodule : prog_tool_model
`default_nettype wire
